// [ccs_regs.svh]
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
// register word indices on the apb word map (matched against paddr[9:2]; the byte address is the index times four)
`define CCS_IDX_DATA      8'hdc
`define CCS_IDX_CMD       8'hdd
`define CCS_IDX_STATUS    8'hde
`define CCS_IDX_MASK      8'hdf
`define CCS_IDX_FLAGS     8'he7
`define CCS_IDX_CLKDIV    8'hed
`define CCS_IDX_CTRL      8'hee
// control register fields
`define CCS_CTRL_CRC_OFF  0
`define CCS_CTRL_FLOW     1
`define CCS_CTRL_IRQ_EN   2
// status register fields
`define CCS_ST_LOCK       0
`define CCS_ST_RESP_FMT   1
`define CCS_ST_RESP_CRC   2
`define CCS_ST_DATA_FMT   3
`define CCS_ST_DATA_CRC   4
`define CCS_ST_BUSY       5
// flag and mask fields
`define CCS_EV_F1_EMPTY   0
`define CCS_EV_F2_EMPTY   1
`define CCS_EV_F1_FULL    2
`define CCS_EV_F2_FULL    3
`define CCS_EV_FRAME      4
`define CCS_EV_CMD        5
`define CCS_EV_RESP       6
`define CCS_EV_BUSY       7
// reset values
`define CCS_RST_MASK      8'hff
`define CCS_RST_PORT      8'hff
`define CCS_RST_FLAGS     8'h00
`define CCS_RST_CLKDIV    8'h00
`define CCS_RST_CTRL      8'h00
`endif

// [ccs_pkg.sv]
package ccs_pkg;
  // byte moving between the register side and a fifo
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ccs_byte_t;
  // line-side status reported by the protocol engine
  typedef struct packed {
    logic card_busy;
    logic data_crc_ok;
    logic data_format_ok;
    logic resp_crc_ok;
    logic resp_format_ok;
    logic cmd_fifo_locked;
  } ccs_line_t;
  // completion pulses and fifo levels from the protocol engine
  typedef struct packed {
    logic response_done;
    logic command_done;
    logic frame_done;
    logic fifo2_full;
    logic fifo1_full;
    logic fifo2_empty;
    logic fifo1_empty;
  } ccs_event_t;
  typedef enum logic [1:0] {
    CCS_CLK_RUN,
    CCS_CLK_STOP
  } ccs_clk_state_t;
endpackage : ccs_pkg

// [ccs_regbank.sv]
// Register access over APB was left to the implementer.
`include "ccs_regs.svh"
// How it works
// RL1: card busy status follows the card's busy indication on the data line.
// RL2: data format status reports token or frame format good, per transfer direction.
// RL3: response crc status set when received response crc7 matches, else cleared.
// RL4: with crc check off the response crc status is meaningless, held at zero.
// RL5: busy change event set on every busy entry and exit, cleared by flag read.
// RL6: response done event set at end of response reception, cleared by flag read.
// RL7: command done event set at end of command send, cleared by flag read.
// RL8: frame done event set at end of stream or block transfer, cleared by flag read.
// RL9: second fifo full flag set when it fills, cleared when it empties.
// RL10: first fifo full flag set when it fills, cleared when it empties.
// RL11: second fifo empty flag set when it empties, cleared when it fills.
// RL12: first fifo empty flag set when it empties, cleared when it fills.
// RL13: eight mask bits block their flags from the interrupt; all reset set.
// RL14: command port read pops response fifo byte, write pushes command fifo byte.
// RL15: data port read pops data fifo byte, write pushes one; resets to ones.
// RL16: card clock is derived from the eight-bit divider value software writes.
// RL17: interrupt requested when any unmasked flag is set and global enable set.
// RL18: with flow control, clock stops when both fifos full, restarts on data access.
// RL19: software saves one flag read and tests each bit from that copy.
// RL20: data crc status reports token crc error or received block crc good.
// RL21: response format status reports format; lock bit forbids command fifo writes; command port writes still push while it is set.
module ccs_regbank (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // line status and events from the protocol engine
  input  wire ccs_pkg::ccs_line_t  line_status,
  input  wire ccs_pkg::ccs_event_t line_events,
  input  wire logic                tx_mode,
  // fifo byte ports
  output ccs_pkg::ccs_byte_t     cmd_push,
  output logic                   resp_pop,
  input  wire logic [7:0]        resp_byte,
  output ccs_pkg::ccs_byte_t     data_push,
  output logic                   data_pop,
  input  wire logic [7:0]        data_byte_in,
  // card clock and interrupt
  output logic                   card_clock,
  output logic                   card_clock_run,
  output logic                   irq
);

  // apb access decode; slave answers in the access cycle with no wait
  wire        access   = psel & penable;
  wire        wr_acc   = access & pwrite;
  wire        rd_acc   = access & ~pwrite;
  wire [7:0]  reg_idx  = paddr[9:2];
  wire        addr_hit = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'b00);

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction : hit

  wire sel_data   = addr_hit & hit(reg_idx, `CCS_IDX_DATA);
  wire sel_cmd    = addr_hit & hit(reg_idx, `CCS_IDX_CMD);
  wire sel_status = addr_hit & hit(reg_idx, `CCS_IDX_STATUS);
  wire sel_mask   = addr_hit & hit(reg_idx, `CCS_IDX_MASK);
  wire sel_flags  = addr_hit & hit(reg_idx, `CCS_IDX_FLAGS);
  wire sel_clkdiv = addr_hit & hit(reg_idx, `CCS_IDX_CLKDIV);
  wire sel_ctrl   = addr_hit & hit(reg_idx, `CCS_IDX_CTRL);
  wire mapped     = sel_data | sel_cmd | sel_status | sel_mask
                  | sel_flags | sel_clkdiv | sel_ctrl;
  // status and flags are read-only; writes there are refused
  wire bad        = ~mapped | (pwrite & (sel_status | sel_flags));

  assign pready  = 1'b1;
  assign pslverr = access & bad;

  // software registers
  logic [7:0] mask_reg, mask_next;
  logic [7:0] clkdiv_reg, clkdiv_next;
  logic [2:0] ctrl_reg, ctrl_next;
  logic [7:0] cmd_port_reg, data_port_reg;

  assign mask_next   = (wr_acc & sel_mask)   ? pwdata[7:0] : mask_reg;   // RL13
  assign clkdiv_next = (wr_acc & sel_clkdiv) ? pwdata[7:0] : clkdiv_reg; // RL16
  assign ctrl_next   = (wr_acc & sel_ctrl)   ? pwdata[2:0] : ctrl_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg   <= `CCS_RST_MASK;
      clkdiv_reg <= `CCS_RST_CLKDIV;
      ctrl_reg   <= 3'(`CCS_RST_CTRL);
    end else begin
      mask_reg   <= mask_next;
      clkdiv_reg <= clkdiv_next;
      ctrl_reg   <= ctrl_next;
    end
  end

  wire crc_off  = ctrl_reg[`CCS_CTRL_CRC_OFF];
  wire flow_on  = ctrl_reg[`CCS_CTRL_FLOW];
  wire irq_en   = ctrl_reg[`CCS_CTRL_IRQ_EN];

  // byte ports: writes push, reads pop; a read shows the fifo's head byte
  assign cmd_push.valid  = wr_acc & sel_cmd;        // RL14
  assign cmd_push.data   = pwdata[7:0];
  assign resp_pop        = rd_acc & sel_cmd;        // RL14
  assign data_push.valid = wr_acc & sel_data;       // RL15
  assign data_push.data  = pwdata[7:0];
  assign data_pop        = rd_acc & sel_data;       // RL15

  // last byte passed through each port, kept internally; a port read shows the fifo head byte, not this copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_port_reg  <= `CCS_RST_PORT;
      data_port_reg <= `CCS_RST_PORT;               // RL15
    end else begin
      if (resp_pop)
        cmd_port_reg <= resp_byte;
      else if (cmd_push.valid)
        cmd_port_reg <= pwdata[7:0];
      if (data_pop)
        data_port_reg <= data_byte_in;
      else if (data_push.valid)
        data_port_reg <= pwdata[7:0];
    end
  end

  // status byte; bits 7:6 read zero
  logic [7:0] status_reg;
  wire  [7:0] status_next;
  assign status_next[`CCS_ST_BUSY]     = line_status.card_busy;               // RL1
  assign status_next[`CCS_ST_DATA_CRC] = tx_mode ? ~line_status.data_crc_ok   // RL20
                                                 : line_status.data_crc_ok;
  assign status_next[`CCS_ST_DATA_FMT] = line_status.data_format_ok;          // RL2
  assign status_next[`CCS_ST_RESP_CRC] = ~crc_off & line_status.resp_crc_ok;  // RL3 RL4
  assign status_next[`CCS_ST_RESP_FMT] = line_status.resp_format_ok;          // RL21
  assign status_next[`CCS_ST_LOCK]     = line_status.cmd_fifo_locked;         // RL21
  assign status_next[7:6]              = 2'b00;

  // busy edge detector for the change event
  logic busy_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 8'h00;
      busy_reg   <= 1'b0;
    end else begin
      status_reg <= status_next;
      busy_reg   <= line_status.card_busy;
    end
  end
  wire busy_edge = busy_reg ^ line_status.card_busy;                          // RL5

  // event flags: read-cleared pulses, set wins over the read in the same cycle
  logic [7:0] flags_reg, flags_next;
  wire        flags_read = rd_acc & sel_flags;                                // RL19
  wire [3:0]  pulse_set  = {busy_edge, line_events.response_done,
                            line_events.command_done, line_events.frame_done};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pulse
      assign flags_next[4 + g] = pulse_set[g] |
                                 (flags_reg[4 + g] & ~flags_read);            // RL5 RL6 RL7 RL8
    end
  endgenerate

  // fifo flags: hardware set on reaching a level, hardware cleared on the opposite
  assign flags_next[`CCS_EV_F2_FULL]  = line_events.fifo2_full |
                                        (flags_reg[`CCS_EV_F2_FULL] & ~line_events.fifo2_empty);  // RL9
  assign flags_next[`CCS_EV_F1_FULL]  = line_events.fifo1_full |
                                        (flags_reg[`CCS_EV_F1_FULL] & ~line_events.fifo1_empty);  // RL10
  assign flags_next[`CCS_EV_F2_EMPTY] = line_events.fifo2_empty |
                                        (flags_reg[`CCS_EV_F2_EMPTY] & ~line_events.fifo2_full);  // RL11
  assign flags_next[`CCS_EV_F1_EMPTY] = line_events.fifo1_empty |
                                        (flags_reg[`CCS_EV_F1_EMPTY] & ~line_events.fifo1_full);  // RL12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags_reg <= `CCS_RST_FLAGS;
    else
      flags_reg <= flags_next;
  end

  // interrupt request, registered so the output is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= irq_en & (|(flags_reg & ~mask_reg));                             // RL13 RL17
  end

  // read mux; the apb data is taken in the same access cycle
  always_comb begin
    prdata = 32'h0;
    if (rd_acc) begin
      if (sel_data)   prdata[7:0] = data_byte_in;
      if (sel_cmd)    prdata[7:0] = resp_byte;
      if (sel_status) prdata[7:0] = status_reg;
      if (sel_mask)   prdata[7:0] = mask_reg;
      if (sel_flags)  prdata[7:0] = flags_reg;
      if (sel_clkdiv) prdata[7:0] = clkdiv_reg;
      if (sel_ctrl)   prdata[2:0] = ctrl_reg;
    end
  end

  // flow control: freeze the card clock when both fifos are full,
  // release on a data port access or when flow control is switched off, so the card bus never races software
  ccs_pkg::ccs_clk_state_t clk_state_reg, clk_state_next;
  wire both_full   = flags_reg[`CCS_EV_F1_FULL] & flags_reg[`CCS_EV_F2_FULL];
  wire data_access = data_pop | data_push.valid;
  always_comb begin
    clk_state_next = clk_state_reg;
    case (clk_state_reg)
      ccs_pkg::CCS_CLK_RUN:
        if (flow_on & both_full) clk_state_next = ccs_pkg::CCS_CLK_STOP;      // RL18
      ccs_pkg::CCS_CLK_STOP:
        if (~flow_on | data_access) clk_state_next = ccs_pkg::CCS_CLK_RUN;    // RL18
      default: clk_state_next = ccs_pkg::CCS_CLK_RUN;
    endcase
  end
  assign card_clock_run = (clk_state_reg == ccs_pkg::CCS_CLK_RUN);

  // card clock divider: toggle every divider+1 pclk cycles while running
  logic [7:0] div_cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_state_reg <= ccs_pkg::CCS_CLK_RUN;
      div_cnt_reg   <= 8'h00;
      card_clock    <= 1'b0;
    end else begin
      clk_state_reg <= clk_state_next;
      if (card_clock_run) begin
        if (div_cnt_reg >= clkdiv_reg) begin                                  // RL16
          div_cnt_reg <= 8'h00;
          card_clock  <= ~card_clock;
        end else begin
          div_cnt_reg <= div_cnt_reg + 8'h01;
        end
      end
    end
  end

endmodule : ccs_regbank

// [ccs_card_model.sv]
module ccs_card_model (
  // fabric clock
  input  wire logic           pclk,
  // pops from the register side
  input  wire logic           resp_pop,
  input  wire logic           data_pop,
  // line side seen by the register side
  output ccs_pkg::ccs_line_t  line_status,
  output ccs_pkg::ccs_event_t line_events,
  output logic                tx_mode,
  output logic [7:0]          resp_byte,
  output logic [7:0]          data_byte_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle card: not busy, no events, heads hold arbitrary bytes
  initial begin
    line_status = '0;
    line_events = '0;
    tx_mode = 1'b0;
    resp_byte = 8'h5a;
    data_byte_in = 8'hc3;
  end
  // the head moves on after every pop, so a stale or doubled pop shows up
  always @(posedge pclk) begin
    if (resp_pop) resp_byte <= {resp_byte[6:0], ~resp_byte[7]};
    if (data_pop) data_byte_in <= data_byte_in + 8'h3b;
  end
  // busy, crc and format levels of the card and engine
  task automatic set_line(input logic [5:0] v, input logic tx);
    line_status <= ccs_pkg::ccs_line_t'(v);
    tx_mode <= tx;
  endtask : set_line
  // completion or fifo level pulse, one cycle long
  task automatic fire(input logic [6:0] v);
    line_events <= ccs_pkg::ccs_event_t'(v);
    @(posedge pclk);
    line_events <= '0;
  endtask : fire
endmodule : ccs_card_model

// [ccs_regbank_monitor.sv]
`include "ccs_regs.svh"
module ccs_regbank_monitor (
  // apb and line side, watched only
  input wire logic               pclk, presetn, psel, penable, pwrite, pslverr,
  input wire logic [31:0]        paddr, pwdata, prdata,
  input wire ccs_pkg::ccs_line_t line_status,
  input wire ccs_pkg::ccs_byte_t cmd_push, data_push,
  input wire logic               resp_pop, data_pop, card_clock, card_clock_run,
  input wire logic [7:0]         resp_byte, data_byte_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access decode
  wire        rd  = psel && penable && !pwrite;
  wire        wr  = psel && penable && pwrite;
  wire [31:0] ad_c = {22'h0, `CCS_IDX_CMD, 2'b00};
  wire [31:0] ad_d = {22'h0, `CCS_IDX_DATA, 2'b00};
  wire [31:0] ad_s = {22'h0, `CCS_IDX_STATUS, 2'b00};
  wire [31:0] ad_f = {22'h0, `CCS_IDX_FLAGS, 2'b00};
  a_cmd_push: assert property (
    wr && paddr == ad_c |-> cmd_push.valid && cmd_push.data == pwdata[7:0])
    else $error("command byte not pushed");
  a_resp_pop: assert property (
    rd && paddr == ad_c |-> resp_pop && prdata == {24'h0, resp_byte})
    else $error("response byte not popped");
  a_data_push: assert property (
    wr && paddr == ad_d |-> data_push.valid && data_push.data == pwdata[7:0])
    else $error("data byte not pushed");
  a_data_pop: assert property (
    rd && paddr == ad_d |-> data_pop && prdata == {24'h0, data_byte_in})
    else $error("data byte not popped");
  a_busy_status: assert property (
    rd && paddr == ad_s |-> prdata[5] == $past(line_status.card_busy))
    else $error("busy status wrong");
  a_ro_refused: assert property (
    wr && (paddr == ad_s || paddr == ad_f) |-> pslverr)
    else $error("write to read-only taken");
  a_idle_quiet: assert property (
    !(psel && penable) |-> !resp_pop && !data_pop && !cmd_push.valid && !data_push.valid)
    else $error("fifo strobe outside access");
  a_frozen_clock: assert property (
    !card_clock_run ##1 !card_clock_run |-> $stable(card_clock))
    else $error("card clock moved while frozen");
  cover property (rd && paddr == ad_f && prdata[7:0] != 8'h00);
  cover property ($fell(card_clock_run));
  cover property (wr && paddr == ad_c);
endmodule : ccs_regbank_monitor
bind ccs_regbank ccs_regbank_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .pslverr, .paddr, .pwdata, .prdata, .line_status, .cmd_push, .data_push, .resp_pop,
  .data_pop, .card_clock, .card_clock_run, .resp_byte, .data_byte_in);

// [tb_card_ctrl_status_irq_regs.sv]
`include "ccs_regs.svh"
module tb_card_ctrl_status_irq_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd_v, v, seed = 33291;
  logic tx_mode, resp_pop, data_pop, card_clock, card_clock_run, irq;
  logic [7:0] resp_byte, data_byte_in;
  ccs_pkg::ccs_line_t line_status;
  ccs_pkg::ccs_event_t line_events;
  ccs_pkg::ccs_byte_t cmd_push, data_push;
  int n_mismatch, n_compared, ef, n;
  ccs_regbank u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .line_status, .line_events, .tx_mode, .cmd_push, .resp_pop, .resp_byte,
    .data_push, .data_pop, .data_byte_in, .card_clock, .card_clock_run, .irq);
  ccs_card_model u_card (.pclk, .resp_pop, .data_pop, .line_status, .line_events, .tx_mode,
    .resp_byte, .data_byte_in);
  // 8 ns fabric clock
  always #4 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one transfer; an idle edge follows so strobes never change twice in a step
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    logic ok;
    psel <= 1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    penable <= 0;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    // request stands until the edge at which pready is seen high; data taken there
    do begin
      @(posedge pclk);
      rd_v = prdata;
      err = pslverr;
      ok = pready;
      n++;
    end while (ok !== 1'b1 && n < 50);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, ok, 1'b1);
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(0, idx, 0);
    chk(rd_v, exp);
  endtask : rdc
  task automatic test_done();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdc(`CCS_IDX_MASK, 8'hff);
    rdc(`CCS_IDX_FLAGS, 0);
    apb(1, `CCS_IDX_STATUS, 32'h3f);
    chk(err, 1);
    apb(0, 8'h40, 0);
    chk(err, 1);
    // random line levels, crc check on or off, either direction
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      apb(1, `CCS_IDX_CTRL, {31'h0, v[8]});
      u_card.set_line(v[5:0], v[6]);
      repeat (2) @(posedge pclk);
      rdc(`CCS_IDX_STATUS, {26'h0, v[5], v[4] ^ v[6], v[3], v[2] & ~v[8], v[1:0]});
    end
    u_card.set_line(0, 0);
    repeat (3) @(posedge pclk);
    apb(0, `CCS_IDX_FLAGS, 0);
    // each event alone; fifo pulses clear their opposite flag, reads clear only 7:4
    for (int k = 0; k < 7; k++) begin
      u_card.fire(7'(1 << k));
      repeat (2) @(posedge pclk);
      ef = (ef | (1 << k)) & ~(k < 4 ? 1 << (k ^ 2) : 0);
      rdc(`CCS_IDX_FLAGS, ef);
      ef &= 'h0f;
      rdc(`CCS_IDX_FLAGS, ef);
    end
    for (int b = 1; b >= 0; b--) begin
      u_card.set_line(6'(b << 5), 0);
      repeat (3) @(posedge pclk);
      rdc(`CCS_IDX_FLAGS, ef | 'h80);
    end
    // fifo 2 full is set: gate it by mask and by global enable
    apb(1, `CCS_IDX_MASK, 8'hf7);
    rdc(`CCS_IDX_MASK, 8'hf7);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    apb(1, `CCS_IDX_CTRL, 4);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    apb(1, `CCS_IDX_MASK, 8'hff);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    // high phase of the card clock lasts divider plus one cycles
    v = rnd() & 'h7;
    apb(1, `CCS_IDX_CLKDIV, v);
    rdc(`CCS_IDX_CLKDIV, v);
    @(posedge card_clock);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (card_clock === 1'b1 && n < 600);
    chk(n, v + 1);
    // both fifos full with flow control: frozen; fifo 1 is reported empty, then a data access restarts it
    apb(1, `CCS_IDX_CTRL, 2);
    repeat (3) @(posedge pclk);
    chk(card_clock_run, 0);
    u_card.fire(7'h01);
    rdc(`CCS_IDX_DATA, u_card.data_byte_in);
    repeat (2) @(posedge pclk);
    chk(card_clock_run, 1);
    v = rnd();
    apb(1, `CCS_IDX_CMD, v);
    apb(1, `CCS_IDX_DATA, v);
    rdc(`CCS_IDX_CMD, u_card.resp_byte);
    test_done();
  end
endmodule : tb_card_ctrl_status_irq_regs
